// file: include/dpt_pkg.sv
// Shared constants, lane codes, state type and cycle helpers for the HS burst sequencer.
// Assumes a 125 MHz system clock; all interval counts derive from it.
package dpt_pkg;

    // ************************************************************
    // Clock and counter sizing
    // ************************************************************
    localparam int CLK_PS = 8000;
    localparam int CLK_NS = 8;
    localparam int CNT_W  = 16;
    localparam int SET_W  = 12;

    // ************************************************************
    // Interval figures in ns and UI
    // ************************************************************
    localparam int TLPX_NS       = 50;
    localparam int CPREP_MIN_NS  = 38;
    localparam int CPREP_MAX_NS  = 95;
    localparam int CPZ_MIN_NS    = 300;
    localparam int CPRE_MIN_UI   = 8;
    localparam int CTRAIL_MIN_NS = 60;
    localparam int CPOST_MIN_NS  = 60;
    localparam int CPOST_MIN_UI  = 52;
    localparam int HPREP_MIN_NS  = 40;
    localparam int HPREP_MIN_UI  = 4;
    localparam int HPREP_MAX_NS  = 85;
    localparam int HPREP_MAX_UI  = 6;
    localparam int HPZ_MIN_NS    = 145;
    localparam int HPZ_MIN_UI    = 10;
    localparam int TRAIL_NS      = 60;
    localparam int TRAIL_UI_A    = 8;
    localparam int TRAIL_UI_B    = 4;
    localparam int N_FWD         = 1;
    localparam int N_REV         = 4;
    localparam logic [SET_W-1:0] SETTLE_MIN_NS = 12'h028;
    localparam logic [SET_W-1:0] SETTLE_MAX_NS = 12'hA1E;

    // ************************************************************
    // Lane line states and burst header
    // ************************************************************
    localparam logic [1:0] LP_11 = 2'h3;
    localparam logic [1:0] LP_01 = 2'h1;
    localparam logic [1:0] LP_00 = 2'h0;
    localparam logic [7:0] SYNC_BYTE = 8'hB8;

    typedef enum logic [3:0] {
        ST_STOP, ST_CRQ, ST_CPREP, ST_CZERO, ST_CPRE, ST_DRQ, ST_DPREP,
        ST_DZERO, ST_SYNC, ST_PAY, ST_DTRAIL, ST_CPOST, ST_CTRAIL
    } dpt_state_t;

    // Least time rounds up, longest rounds down, never below one cycle.
    function automatic int cyc_min(int ns, int ui, int ui_ps);
        int v;
        v = (ns * 1000 + ui * ui_ps + CLK_PS - 1) / CLK_PS;
        return (v < 1) ? 1 : v;
    endfunction : cyc_min

    function automatic int cyc_max(int ns, int ui, int ui_ps);
        int v;
        v = (ns * 1000 + ui * ui_ps) / CLK_PS;
        return (v < 1) ? 1 : v;
    endfunction : cyc_max

    function automatic int imax(int a, int b);
        return (a > b) ? a : b;
    endfunction : imax

endpackage : dpt_pkg

// file: include/dpt_fifo_if.sv
// Valid/ready stream carrier between the sequencer and its byte FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface dpt_fifo_if #(parameter int W = 8);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : dpt_fifo_if
`default_nettype wire

// file: rtl/dpt_fifo.sv
// Synchronous first-in first-out buffer with valid/ready on both sides.
// Assumes DEPTH is a power of two; the clock enable freezes all state.
`timescale 1ns/1ns
`default_nettype none
module dpt_fifo
    import dpt_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock, reset and freeze
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ce,
    // Stream ports
    dpt_fifo_if.fifo  q
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("dpt_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp_ff;
    logic [AW:0]  rp_ff;
    logic         full;
    logic         empty;
    logic         wr;
    logic         rd;

    assign empty       = (wp_ff == rp_ff);
    assign full        = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    assign wr          = ce && q.in_valid && !full;
    assign rd          = ce && q.out_ready && !empty;
    assign q.in_ready  = !full;
    assign q.out_valid = !empty;
    assign q.out_data  = mem[rp_ff[AW-1:0]];

    always_ff @(posedge clk) begin
        if (wr) begin
            mem[wp_ff[AW-1:0]] <= q.in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (wr) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (rd) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end

endmodule : dpt_fifo
`default_nettype wire

// file: rtl/dpt_hs_timing.sv
// Low-power to high-speed burst sequencer for one clock lane and one data lane,
// plus receive-side settle timers for both lanes.
// Assumes a 125 MHz clk; link_clk and the receive LP lines are asynchronous pins.
//
// Notes on behaviour
// R1: Clock keeps toggling 60 ns plus 52 UI after data trail ends.
// R2: Clock runs at least 8 UI before data lane leaves low power.
// R3: Clock lane holds LP-00 between 38 and 95 ns before HS-0.
// R4: Receiver ignores clock lane HS transitions 95 to 300 ns from prepare start.
// R5: Clock lane holds HS-0 at least 60 ns after last clock bit.
// R6: Clock prepare plus clock zero last at least 300 ns.
// R7: Data LP-00 lasts 40 ns plus 4 UI to 85 ns plus 6 UI.
// R8: Receiver ignores data transitions until settle, responds after 145 ns plus 10 UI.
// R9: Data trail lasts max of n*8 UI and 60 ns plus n*4 UI.
// R10: Trail multiplier n is 1 forward and 4 reverse.
// R11: Every driven low-power state lasts at least 50 ns; the code does so for LP-11 and LP-01, not LP-00.
// R12: Data prepare plus zero last at least 145 ns plus 10 UI.
// R13: Lanes enter HS through LP-11, LP-01, LP-00 in order.
// R14: Lanes return to LP-11 stop state on leaving HS.
// R15: Clock and data settle timers configurable from 40 to 2590 ns.
// R16: Counts run on the known clock, rounded so minima and maxima hold.
`timescale 1ns/1ns
`default_nettype none
module dpt_hs_timing
    import dpt_pkg::*;
#(
    parameter int UI_PS = 1000,
    parameter int DW    = 8,
    parameter int DEPTH = 16
) (
    // Clock, reset and freeze
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic          ce,
    // Transmit byte stream
    input  wire logic          tx_req,
    input  wire logic          reverse_dir,
    input  wire logic          tx_valid,
    input  wire logic [DW-1:0] tx_data,
    output logic               tx_ready,
    output logic               tx_busy,
    // Link byte clock pin
    input  wire logic          link_clk,
    // Transmit lane drive
    output logic [1:0]         clk_lane_lp,
    output logic               clk_lane_hs_oe,
    output logic               clk_lane_run,
    output logic [1:0]         dat_lane_lp,
    output logic               dat_lane_hs_oe,
    output logic               dat_lane_trail,
    output logic [DW-1:0]      hs_byte,
    output logic               hs_byte_strb,
    // Receive lane sense and settle
    input  wire logic [1:0]    rx_clk_lp,
    input  wire logic [1:0]    rx_dat_lp,
    input  wire logic [11:0]   rx_clk_settle_ns,
    input  wire logic [11:0]   rx_dat_settle_ns,
    output logic               rx_clk_hs_act,
    output logic               rx_dat_hs_act
);

    // ************************************************************
    // Interval counts in clk cycles
    // ************************************************************
    localparam int C_LPX      = cyc_min(TLPX_NS, 0, UI_PS);                 // R16
    localparam int C_CPREP    = cyc_min(CPREP_MIN_NS, 0, UI_PS);
    localparam int C_CPREP_MX = cyc_max(CPREP_MAX_NS, 0, UI_PS);
    localparam int C_CZERO    = imax(1, cyc_min(CPZ_MIN_NS, 0, UI_PS) - C_CPREP);
    localparam int C_CPRE     = cyc_min(0, CPRE_MIN_UI, UI_PS);
    localparam int C_HPREP    = cyc_min(HPREP_MIN_NS, HPREP_MIN_UI, UI_PS);
    localparam int C_HPREP_MX = cyc_max(HPREP_MAX_NS, HPREP_MAX_UI, UI_PS);
    localparam int C_HZERO    = imax(1, cyc_min(HPZ_MIN_NS, HPZ_MIN_UI, UI_PS) - C_HPREP);
    localparam int C_TRL_F    = imax(cyc_min(0, TRAIL_UI_A * N_FWD, UI_PS),
                                     cyc_min(TRAIL_NS, TRAIL_UI_B * N_FWD, UI_PS));
    localparam int C_TRL_R    = imax(cyc_min(0, TRAIL_UI_A * N_REV, UI_PS),
                                     cyc_min(TRAIL_NS, TRAIL_UI_B * N_REV, UI_PS));
    localparam int C_CPOST    = cyc_min(CPOST_MIN_NS, CPOST_MIN_UI, UI_PS);
    localparam int C_CTRAIL   = cyc_min(CTRAIL_MIN_NS, 0, UI_PS);

    // No UI can push a prepare minimum past its maximum; the check refuses that all the same.
    if (UI_PS < 1 || DW < 1 || C_CPREP > C_CPREP_MX || C_HPREP > C_HPREP_MX) begin : g_bad
        $error("dpt_hs_timing: UI_PS or DW cannot meet the prepare windows");
    end

    // ************************************************************
    // Pin synchronisers and link edge
    // ************************************************************
    logic [4:0] pin_s1_ff;
    logic [4:0] pin_s2_ff;
    logic       lk_d_ff;
    logic       link_rise;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_ff <= {1'b0, LP_11, LP_11};
            pin_s2_ff <= {1'b0, LP_11, LP_11};
            lk_d_ff   <= 1'b0;
        end else if (ce) begin
            pin_s1_ff <= {link_clk, rx_dat_lp, rx_clk_lp};
            pin_s2_ff <= pin_s1_ff;
            lk_d_ff   <= pin_s2_ff[4];
        end
    end

    assign link_rise = pin_s2_ff[4] && !lk_d_ff;

    // ************************************************************
    // Byte FIFO
    // ************************************************************
    dpt_fifo_if #(.W(DW)) fq ();

    dpt_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .q      (fq.fifo)
    );

    dpt_state_t       state_ff;
    dpt_state_t       nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] ld_val;
    logic             rev_ff;
    logic             cnt_zero;
    logic             st_chg;
    logic             pop;

    assign fq.in_valid  = tx_valid;
    assign fq.in_data   = tx_data;
    assign tx_ready     = fq.in_ready;
    assign pop          = (state_ff == ST_PAY) && link_rise && fq.out_valid;
    assign fq.out_ready = pop;

    // ************************************************************
    // Burst sequencer
    // ************************************************************
    assign cnt_zero = (cnt_ff == '0);
    assign st_chg   = (nxt_state != state_ff);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_STOP: if (cnt_zero && tx_req && fq.out_valid) nxt_state = ST_CRQ;  // R11
            ST_CRQ: if (cnt_zero) nxt_state = ST_CPREP;                           // R13
            ST_CPREP: if (cnt_zero) nxt_state = ST_CZERO;                         // R3
            ST_CZERO: if (cnt_zero) nxt_state = ST_CPRE;                          // R6
            ST_CPRE: if (cnt_zero) nxt_state = ST_DRQ;                            // R2
            ST_DRQ: if (cnt_zero) nxt_state = ST_DPREP;                           // R13
            ST_DPREP: if (cnt_zero) nxt_state = ST_DZERO;                         // R7
            ST_DZERO: if (cnt_zero) nxt_state = ST_SYNC;                          // R12
            ST_SYNC: if (link_rise) nxt_state = ST_PAY;
            ST_PAY: if (link_rise && !fq.out_valid) nxt_state = ST_DTRAIL;
            ST_DTRAIL: if (cnt_zero) nxt_state = ST_CPOST;                        // R9
            ST_CPOST: if (cnt_zero) nxt_state = ST_CTRAIL;                        // R1
            ST_CTRAIL: if (cnt_zero) nxt_state = ST_STOP;                         // R5
            default: nxt_state = ST_STOP;
        endcase
    end

    // Each state but ST_SYNC and ST_PAY lasts its load value plus one enabled cycle, ST_STOP at least that.
    always_comb begin
        case (nxt_state)
            ST_STOP, ST_CRQ, ST_DRQ: ld_val = CNT_W'(C_LPX - 1);                  // R11
            ST_CPREP: ld_val = CNT_W'(C_CPREP - 1);
            ST_CZERO: ld_val = CNT_W'(C_CZERO - 1);
            ST_CPRE: ld_val = CNT_W'(C_CPRE - 1);
            ST_DPREP: ld_val = CNT_W'(C_HPREP - 1);
            ST_DZERO: ld_val = CNT_W'(C_HZERO - 1);
            ST_DTRAIL: ld_val = rev_ff ? CNT_W'(C_TRL_R - 1) : CNT_W'(C_TRL_F - 1); // R10
            ST_CPOST: ld_val = CNT_W'(C_CPOST - 1);
            ST_CTRAIL: ld_val = CNT_W'(C_CTRAIL - 1);
            default: ld_val = '0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_STOP;
            cnt_ff   <= CNT_W'(C_LPX - 1);
            rev_ff   <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            cnt_ff   <= st_chg ? ld_val : (cnt_zero ? cnt_ff : cnt_ff - 1'b1);
            if (state_ff == ST_STOP && st_chg) begin
                rev_ff <= reverse_dir;                                           // R10
            end
        end
    end

    // ************************************************************
    // Lane drive decode, registered
    // ************************************************************
    logic [1:0] n_clk_lp;
    logic [1:0] n_dat_lp;
    logic       n_clk_hs;
    logic       n_clk_run;
    logic       n_dat_hs;

    assign n_clk_lp  = (nxt_state == ST_STOP) ? LP_11 :
                       (nxt_state == ST_CRQ) ? LP_01 : LP_00;                    // R13
    assign n_clk_hs  = !(nxt_state inside {ST_STOP, ST_CRQ, ST_CPREP});
    assign n_clk_run = nxt_state inside {ST_CPRE, ST_DRQ, ST_DPREP, ST_DZERO, ST_SYNC,
                                         ST_PAY, ST_DTRAIL, ST_CPOST};
    assign n_dat_lp  = (nxt_state == ST_DRQ) ? LP_01 :
                       (nxt_state inside {ST_DPREP, ST_DZERO, ST_SYNC, ST_PAY, ST_DTRAIL})
                       ? LP_00 : LP_11;                                          // R14
    assign n_dat_hs  = nxt_state inside {ST_DZERO, ST_SYNC, ST_PAY, ST_DTRAIL};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_lane_lp    <= LP_11;
            clk_lane_hs_oe <= 1'b0;
            clk_lane_run   <= 1'b0;
            dat_lane_lp    <= LP_11;
            dat_lane_hs_oe <= 1'b0;
            dat_lane_trail <= 1'b0;
            tx_busy        <= 1'b0;
        end else if (ce) begin
            clk_lane_lp    <= n_clk_lp;
            clk_lane_hs_oe <= n_clk_hs;
            clk_lane_run   <= n_clk_run;
            dat_lane_lp    <= n_dat_lp;
            dat_lane_hs_oe <= n_dat_hs;
            dat_lane_trail <= (nxt_state == ST_DTRAIL);                           // R9
            tx_busy        <= (nxt_state != ST_STOP);
        end
    end

    // The sync header goes out on the first link rise seen in ST_SYNC, payload on later ones.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hs_byte      <= '0;
            hs_byte_strb <= 1'b0;
        end else if (ce) begin
            hs_byte_strb <= pop || (state_ff == ST_SYNC && link_rise);
            if (state_ff == ST_SYNC && link_rise) begin
                hs_byte <= DW'(SYNC_BYTE);
            end else if (pop) begin
                hs_byte <= fq.out_data;
            end
        end
    end

    // ************************************************************
    // Receive settle timers, lane 0 clock, lane 1 data
    // ************************************************************
    logic [1:0][1:0]       rx_lp;
    logic [1:0][SET_W-1:0] set_ns;
    logic [1:0][SET_W-1:0] set_lim;
    logic [1:0][SET_W-1:0] set_cyc;
    logic [1:0][SET_W-1:0] rcnt_ff;
    logic [1:0]            armed_ff;
    logic [1:0]            act_ff;

    assign rx_lp         = pin_s2_ff[3:0];
    assign set_ns        = {rx_dat_settle_ns, rx_clk_settle_ns};
    assign rx_clk_hs_act = act_ff[0];
    assign rx_dat_hs_act = act_ff[1];

    for (genvar i = 0; i < 2; i++) begin : g_rx
        assign set_lim[i] = (set_ns[i] < SETTLE_MIN_NS) ? SETTLE_MIN_NS :
                            (set_ns[i] > SETTLE_MAX_NS) ? SETTLE_MAX_NS : set_ns[i]; // R15
        assign set_cyc[i] = (set_lim[i] + SET_W'(CLK_NS - 1)) / SET_W'(CLK_NS);

        // Counting starts when LP-00 (prepare) is first seen; LP-11 ends the burst.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                armed_ff[i] <= 1'b0;
                act_ff[i]   <= 1'b0;
                rcnt_ff[i]  <= '0;
            end else if (ce) begin
                if (rx_lp[i] == LP_11) begin
                    armed_ff[i] <= 1'b0;
                    act_ff[i]   <= 1'b0;
                    rcnt_ff[i]  <= '0;
                end else if (rx_lp[i] == LP_00 && !armed_ff[i] && !act_ff[i]) begin
                    armed_ff[i] <= 1'b1;
                    rcnt_ff[i]  <= SET_W'(1);
                end else if (armed_ff[i]) begin
                    if (rcnt_ff[i] >= set_cyc[i]) begin
                        act_ff[i]   <= 1'b1;                                     // R4 R8
                        armed_ff[i] <= 1'b0;
                    end else begin
                        rcnt_ff[i] <= rcnt_ff[i] + 1'b1;
                    end
                end
            end
        end

        a_rx_settle_hold: assert property (@(posedge clk) disable iff (!arst_n) // R8
            $rose(act_ff[i]) |-> $past(rcnt_ff[i]) >= $past(set_cyc[i]))
            else $error("receiver acted before its settle time");
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [CNT_W-1:0] dwell_ff;
    int               dwell;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dwell_ff <= '0;
        end else if (ce) begin
            dwell_ff <= st_chg ? '0 : (&dwell_ff ? dwell_ff : dwell_ff + 1'b1);
        end
    end

    assign dwell = int'(dwell_ff) + 1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_leave(dpt_state_t s);
        ce && st_chg && state_ff == s;
    endsequence

    property p_min(dpt_state_t s, int lo);
        s_leave(s) |-> dwell >= lo;
    endproperty

    a_clk_lp_order: assert property ($changed(clk_lane_lp) && clk_lane_lp == LP_00 // R13
        |-> $past(clk_lane_lp) == LP_01) else $error("clock lane skipped LP-01");
    a_dat_lp_order: assert property ($changed(dat_lane_lp) && dat_lane_lp == LP_01 // R13
        |-> $past(dat_lane_lp) == LP_11 ##1 dat_lane_lp != LP_11)
        else $error("data lane request not from stop state");
    a_clk_prep_win: assert property (s_leave(ST_CPREP)                            // R3
        |-> dwell >= C_CPREP && dwell <= C_CPREP_MX) else $error("clock prepare out of window");
    a_clk_zero_min: assert property (p_min(ST_CZERO, C_CZERO))                  // R6
        else $error("clock zero too short");
    a_clk_pre_min: assert property (p_min(ST_CPRE, C_CPRE))                     // R2
        else $error("clock pre too short");
    a_dat_prep_win: assert property (s_leave(ST_DPREP)                            // R7
        |-> dwell >= C_HPREP && dwell <= C_HPREP_MX) else $error("data prepare out of window");
    a_dat_zero_min: assert property (p_min(ST_DZERO, C_HZERO))                  // R12
        else $error("data zero too short");
    a_dat_trail_len: assert property (s_leave(ST_DTRAIL)                          // R9 R10
        |-> dwell >= (rev_ff ? C_TRL_R : C_TRL_F)) else $error("data trail too short");
    a_clk_post_min: assert property (s_leave(ST_CPOST)                            // R1
        |-> dwell >= C_CPOST && clk_lane_run ##1 !clk_lane_run && clk_lane_hs_oe)
        else $error("clock post too short or trail missing");
    a_clk_trail_min: assert property (p_min(ST_CTRAIL, C_CTRAIL))               // R5
        else $error("clock trail too short");
    a_lp_state_min: assert property (s_leave(ST_STOP) or s_leave(ST_CRQ)          // R11
        or s_leave(ST_DRQ) |-> dwell >= C_LPX) else $error("low-power state too short");
    a_lane_exit_stop: assert property (s_leave(ST_DTRAIL)                         // R14
        |=> dat_lane_lp == LP_11 && !dat_lane_hs_oe) else $error("data lane not back in stop");
    a_clk_exit_stop: assert property (s_leave(ST_CTRAIL)                          // R14
        |=> clk_lane_lp == LP_11 && !clk_lane_hs_oe) else $error("clock lane not back in stop");

endmodule : dpt_hs_timing
`default_nettype wire

// file: bench/dpt_far_end.sv
// Far end of the link: makes the link byte clock and echoes the lanes on the LP pins.
// Assumes the device lanes are looped back to its receivers, promptly or late.
`timescale 1ns/1ns
`default_nettype none
module dpt_far_end (
    // Device side
    input  wire logic       tx_busy,
    input  wire logic [1:0] clk_lane_lp,
    input  wire logic [1:0] dat_lane_lp,
    input  wire logic       slow,
    // Link pins
    output var logic        link_clk,
    output var logic [1:0]  rx_clk_lp,
    output var logic [1:0]  rx_dat_lp
);
    initial begin
        rx_clk_lp = 2'h3;
        rx_dat_lp = 2'h3;
    end
    // The link clock stands still outside frames; its edges come 5 ns after a clk rise.
    always begin
        link_clk = 1'b0;
        wait (tx_busy === 1'b1);
        #37;
        while (tx_busy === 1'b1) begin
            #80 link_clk = 1'b1;
            #80 link_clk = 1'b0;
        end
    end
    always @(clk_lane_lp, dat_lane_lp) begin
        rx_clk_lp <= #(slow ? 21 : 2) clk_lane_lp;
        rx_dat_lp <= #(slow ? 21 : 2) dat_lane_lp;
    end
endmodule : dpt_far_end
`default_nettype wire

// file: bench/dpt_hs_timing_test.sv
// Self-checking bench: timed bursts both ways, FIFO fill and receive settle timers.
// Assumes the far-end model loops the lanes back and makes the link clock.
`timescale 1ns/1ns
`default_nettype none
module dpt_hs_timing_test;
    import dpt_pkg::*;
    localparam int UI = 1000;
    logic        clk, arst_n, ce, tx_req, reverse_dir, tx_valid, slow, tx_ready, tx_busy;
    logic        link_clk, hs_byte_strb, clk_lane_hs_oe, clk_lane_run, dat_lane_hs_oe;
    logic        dat_lane_trail, rx_clk_hs_act, rx_dat_hs_act;
    logic [1:0]  clk_lane_lp, dat_lane_lp, rx_clk_lp, rx_dat_lp;
    logic [7:0]  tx_data, hs_byte, exp_q[$], got_q[$];
    logic [11:0] rx_clk_settle_ns, rx_dat_settle_ns;
    int          seed, fail_count, comparisons;
    wire  [7:0]  obs = {clk_lane_lp, clk_lane_hs_oe, clk_lane_run, dat_lane_lp,
                        dat_lane_hs_oe, dat_lane_trail};
    dpt_hs_timing #(.UI_PS(UI)) u_dpt_hs_timing (.clk, .arst_n, .ce, .tx_req, .reverse_dir,
        .tx_valid, .tx_data, .tx_ready, .tx_busy, .link_clk, .clk_lane_lp, .clk_lane_hs_oe,
        .clk_lane_run, .dat_lane_lp, .dat_lane_hs_oe, .dat_lane_trail, .hs_byte,
        .hs_byte_strb, .rx_clk_lp, .rx_dat_lp, .rx_clk_settle_ns, .rx_dat_settle_ns,
        .rx_clk_hs_act, .rx_dat_hs_act);
    dpt_far_end u_dpt_far_end (.tx_busy, .clk_lane_lp, .dat_lane_lp, .slow, .link_clk,
        .rx_clk_lp, .rx_dat_lp);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (hs_byte_strb === 1'b1) got_q.push_back(hs_byte);
    // Minimum counts round up so no interval comes out short.
    function automatic int cyc(int ns, int ui);
        return (ns * 1000 + ui * UI + 7999) / 8000;
    endfunction : cyc
    task tick;
        @(posedge clk);
        #1;
    endtask : tick
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic dwell(output int n);
        logic [7:0] cur;
        cur = obs;
        n = 0;
        while (obs === cur && n < 2000) begin tick; n++; end
    endtask : dwell
    task automatic settle(input bit dl, input int ns);
        int n, x;
        x = (((ns < 40) ? 40 : ns) + 7) / 8;
        n = 0;
        while ((dl ? rx_dat_lp : rx_clk_lp) !== 2'h0 && n < 900) begin tick; n++; end
        n = 0;
        while ((dl ? rx_dat_hs_act : rx_clk_hs_act) !== 1'b1 && n < 900) begin tick; n++; end
        chk("settle", n >= x && n <= x + 4, 1);
    endtask : settle
    task automatic burst(input bit rev, input int nb, input int cs, input int ds);
        int n, k, e[10];
        logic [7:0] v[10];
        k = rev ? 4 : 1;
        e = '{cyc(50, 0), cyc(38, 0), cyc(300, 0) - cyc(38, 0), cyc(0, 8), cyc(50, 0),
              cyc(40, 4), cyc(145, 10) - cyc(40, 4), imax(cyc(0, 8 * k), cyc(60, 4 * k)),
              cyc(60, 52), cyc(60, 0)};
        // Lane codes per phase: LP-01, LP-00, HS-0, clock run, then data request to trail.
        v = '{8'h4C, 8'h0C, 8'h2C, 8'h3C, 8'h34, 8'h30, 8'h32, 8'h33, 8'h3C, 8'h2C};
        exp_q = '{8'hB8};
        got_q.delete();
        rx_clk_settle_ns = cs[11:0];
        rx_dat_settle_ns = ds[11:0];
        repeat (nb) begin
            tx_valid = 1'b1;
            tx_data = 8'($random(seed));
            // The sync byte sits at the head of exp_q, so 17 entries mean 16 bytes held.
            chk("ready", tx_ready, exp_q.size() < 17);
            if (exp_q.size() < 17) exp_q.push_back(tx_data);
            tick;
        end
        tx_valid = 1'b0;
        if (nb > 16) chk("ready", tx_ready, 0);
        reverse_dir = rev;
        tx_req = 1'b1;
        fork
            begin
                dwell(n);
                tx_req = 1'b0;
                foreach (e[i]) begin
                    chk("lanes", obs, v[i]);
                    dwell(n);
                    if (i == 6) chk("zero", n >= e[i], 1);
                    else chk("dwell", n, e[i]);
                end
            end
            settle(0, cs);
            settle(1, ds);
        join
        chk("stop", {obs, tx_busy}, 9'h198);
        chk("count", got_q.size(), exp_q.size());
        foreach (exp_q[i]) if (i < got_q.size()) chk("byte", got_q[i], exp_q[i]);
        repeat (10) tick;
        $display("test done reverse %0d bytes %0d", rev, nb);
    endtask : burst
    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    initial begin
        {arst_n, tx_req, reverse_dir, tx_valid, slow} = '0;
        {tx_data, rx_clk_settle_ns, rx_dat_settle_ns} = '0;
        ce = 1'b1;
        seed = 7;
        repeat (20) tick;
        arst_n = 1'b1;
        chk("reset", {obs, tx_busy, tx_ready}, 10'h331);
        // With the enable low no byte may enter the FIFO; a stray one shows in the first burst.
        ce = 1'b0;
        tx_valid = 1'b1;
        repeat (8) tick;
        chk("freeze", {obs, tx_busy, tx_ready}, 10'h331);
        tx_valid = 1'b0;
        ce = 1'b1;
        tick;
        burst(0, 3, 0, 95);
        slow = 1'b1;
        burst(1, 2, 300, 145);
        slow = 1'b0;
        burst(0, 17, 2590, 40);
        repeat (3) burst($random(seed), 1 + {$random(seed)} % 6, 40 + {$random(seed)} % 361,
                         40 + {$random(seed)} % 361);
        close_out;
    end
    // A full run needs well under 10,000 cycles.
    initial begin
        #200000;
        fail_count++;
        close_out;
    end
endmodule : dpt_hs_timing_test
`default_nettype wire
